// ==== design/trp_table_read_guard.sv ====
// Table read protection check with APB configuration and identity registers
// Functional notes
// (R1) Guard off refuses foreign reads of block 3
// (R2) Guard off refuses foreign reads of block 2
// (R3) Guard off refuses foreign reads of block 1
// (R4) Guard off refuses foreign reads of block 0
// (R5) Guard off refuses foreign reads of boot block
// (R6) Part number split: low 3, high 8
// (R7) Revision field beside low part bits
// (R8) Live check; same block allowed; fixed value
`timescale 1ns/1ns
module trp_table_read_guard (
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  // APB slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [trp_pkg::APB_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                     pwdata,
  input  wire logic [3:0]                      pstrb,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // Table read request from the core
  input  wire logic                            tr_valid,
  input  wire logic [trp_pkg::TR_ADDR_W-1:0]   tr_addr,
  input  wire logic [trp_pkg::TR_ADDR_W-1:0]   tr_pc,
  // Program memory read port
  output logic      [trp_pkg::TR_ADDR_W-1:0]   mem_addr,
  input  wire logic [trp_pkg::TR_DATA_W-1:0]   mem_rdata,
  // Result to the core
  output logic                                 tr_rvalid,
  output logic      [trp_pkg::TR_DATA_W-1:0]   tr_rdata,
  output logic                                 tr_blocked
);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [7:0]                       table_read_protect_low;
  logic [7:0]                       table_read_protect_high;
  logic [7:0]                       identity_low;
  logic [7:0]                       identity_high;
  logic                             bus_setup;
  logic                             bus_write;
  logic                             addr_hit;
  logic [31:0]                      next_prdata;
  logic                             next_pslverr;

  // Identity fields fixed in silicon
  assign identity_low  = {trp_pkg::PART_NUMBER[2:0], trp_pkg::SILICON_REVISION}; // [R6] [R7]
  assign identity_high = trp_pkg::PART_NUMBER[10:3];                             // [R6]

  assign bus_setup = psel && !penable;
  assign bus_write = psel && penable && pready && pwrite;
  assign pready    = penable;

  always_comb begin
    addr_hit = 1'b1;
    case (paddr)
      trp_pkg::OFS_PROTECT_LOW:   next_prdata = {24'h000000, table_read_protect_low};
      trp_pkg::OFS_PROTECT_HIGH:  next_prdata = {24'h000000, table_read_protect_high};
      trp_pkg::OFS_IDENTITY_LOW:  next_prdata = {24'h000000, identity_low};   // [R6] [R7]
      trp_pkg::OFS_IDENTITY_HIGH: next_prdata = {24'h000000, identity_high};  // [R6]
      default: begin
        next_prdata = 32'h00000000;
        addr_hit    = 1'b0;
      end
    endcase
    next_pslverr = !addr_hit;
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (bus_setup) begin
      prdata  <= pwrite ? 32'h00000000 : next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Writes to the protection bits; identity registers ignore writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      table_read_protect_low  <= trp_pkg::PROTECT_LOW_RST;
      table_read_protect_high <= trp_pkg::PROTECT_HIGH_RST;
    end else if (bus_write && pstrb[0]) begin
      if (paddr == trp_pkg::OFS_PROTECT_LOW) begin
        table_read_protect_low <= pwdata[7:0] & trp_pkg::PROTECT_LOW_MASK;
      end
      if (paddr == trp_pkg::OFS_PROTECT_HIGH) begin
        table_read_protect_high <= pwdata[7:0] & trp_pkg::PROTECT_HIGH_MASK;
      end
    end
  end

  // ****************************************************************
  // Protection check
  // ****************************************************************
  logic [trp_pkg::REGION_NUM-1:0]  guard;
  logic [trp_pkg::REGION_NUM-1:0]  target_rgn;
  logic [trp_pkg::REGION_NUM-1:0]  code_rgn;
  logic [trp_pkg::REGION_NUM-1:0]  deny;
  logic                            next_blocked;

  assign guard[trp_pkg::RGN_BOOT] = table_read_protect_high[trp_pkg::BIT_BOOT_GUARD];
  assign guard[trp_pkg::RGN_BLK0] = table_read_protect_low[trp_pkg::BIT_BLOCK0_GUARD];
  assign guard[trp_pkg::RGN_BLK1] = table_read_protect_low[trp_pkg::BIT_BLOCK1_GUARD];
  assign guard[trp_pkg::RGN_BLK2] = table_read_protect_low[trp_pkg::BIT_BLOCK2_GUARD];
  assign guard[trp_pkg::RGN_BLK3] = table_read_protect_low[trp_pkg::BIT_BLOCK3_GUARD];

  trp_region_decode u_target (
    .addr   (tr_addr),
    .region (target_rgn)
  );

  trp_region_decode u_code (
    .addr   (tr_pc),
    .region (code_rgn)
  );

  // Guard low, target in region, code elsewhere
  genvar g;
  generate
    for (g = 0; g < trp_pkg::REGION_NUM; g++) begin : g_deny
      assign deny[g] = target_rgn[g] && !code_rgn[g] && !guard[g]; // [R1] [R2] [R3] [R4] [R5] [R8]
    end
  endgenerate

  assign next_blocked = |deny;
  assign mem_addr     = tr_addr;

  // Result one cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tr_rvalid  <= 1'b0;
      tr_blocked <= 1'b0;
      tr_rdata   <= trp_pkg::BLOCKED_DATA;
    end else begin
      tr_rvalid <= tr_valid;
      if (tr_valid) begin
        tr_blocked <= next_blocked;
        tr_rdata   <= next_blocked ? trp_pkg::BLOCKED_DATA : mem_rdata; // [R8]
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_block3_refuse: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    tr_valid && tr_addr >= 21'h003000 && tr_addr <= 21'h003FFF
      && !(tr_pc >= 21'h003000 && tr_pc <= 21'h003FFF)
      && !table_read_protect_low[3]
    |=> tr_rvalid && tr_blocked && tr_rdata == 8'h00)
    else $error("block 3 foreign read not refused");

  chk_block2_refuse: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    tr_valid && tr_addr >= 21'h002000 && tr_addr <= 21'h002FFF
      && !(tr_pc >= 21'h002000 && tr_pc <= 21'h002FFF)
    |=> tr_blocked == !$past(table_read_protect_low[2]))
    else $error("block 2 guard decision wrong");

  chk_block1_refuse: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
    tr_valid && tr_addr >= 21'h001000 && tr_addr <= 21'h001FFF
      && (tr_pc < 21'h001000 || tr_pc > 21'h001FFF)
    |=> tr_blocked == !$past(table_read_protect_low[1]))
    else $error("block 1 guard decision wrong");

  chk_block0_refuse: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    tr_valid && tr_addr >= 21'h000200 && tr_addr <= 21'h000FFF
      && (tr_pc < 21'h000200 || tr_pc > 21'h000FFF)
    |=> tr_blocked == !$past(table_read_protect_low[0]))
    else $error("block 0 guard decision wrong");

  chk_boot_refuse: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    tr_valid && tr_addr <= 21'h0001FF && tr_pc > 21'h0001FF
      && table_read_protect_high[0] == 1'b0
    ##1 1'b1 |-> tr_rvalid && tr_blocked)
    else $error("boot block foreign read not refused");

  chk_part_number: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
    psel && !penable && !pwrite && paddr == 12'h00C
    |=> prdata == {24'h000000, trp_pkg::PART_NUMBER[10:3]} && pready)
    else $error("identity high read wrong");

  chk_revision_field: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
    psel && !penable && !pwrite && paddr == 12'h008
    |=> prdata[4:0] == trp_pkg::SILICON_REVISION
      && prdata[7:5] == trp_pkg::PART_NUMBER[2:0] && prdata[31:8] == 24'h000000)
    else $error("identity low read wrong");

  chk_same_block_pass: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    tr_valid && (target_rgn & code_rgn) != 5'h00
    |=> !tr_blocked && tr_rdata == $past(mem_rdata))
    else $error("same block read was blocked");

  chk_unguarded_pass: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    tr_valid && table_read_protect_low[3:0] == 4'hF && table_read_protect_high[0]
    |=> tr_rvalid && !tr_blocked)
    else $error("read blocked with all guards set");

  // ****************************************************************
  // Result timing and data checks
  // ****************************************************************
  chk_rvalid_pulse: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    tr_valid |=> tr_rvalid)
    else $error("table read result missing");

  chk_rvalid_idle: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    !tr_valid |=> !tr_rvalid)
    else $error("table read result without request");

  chk_result_hold: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    !tr_valid |=> $stable(tr_blocked) && $stable(tr_rdata))
    else $error("table read result changed while idle");

  chk_blocked_data: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    tr_rvalid && tr_blocked |-> tr_rdata == 8'h00)
    else $error("refused read returned memory data");

  chk_above_map_pass: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    tr_valid && tr_addr > 21'h003FFF
    |=> !tr_blocked && tr_rdata == $past(mem_rdata))
    else $error("read above the guarded map refused");

  chk_mem_addr_follow: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    tr_valid |-> mem_addr == tr_addr)
    else $error("memory address differs from request");

  // ****************************************************************
  // Own block and guard set checks
  // ****************************************************************
  chk_block3_allow: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    tr_valid && tr_addr >= 21'h003000 && tr_addr <= 21'h003FFF
      && table_read_protect_low[3]
    |=> !tr_blocked && tr_rdata == $past(mem_rdata))
    else $error("block 3 read refused with guard set");

  chk_block3_same: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    tr_valid && tr_addr >= 21'h003000 && tr_addr <= 21'h003FFF
      && tr_pc >= 21'h003000 && tr_pc <= 21'h003FFF
    |=> !tr_blocked)
    else $error("block 3 read from own block refused");

  chk_block2_same: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    tr_valid && tr_addr >= 21'h002000 && tr_addr <= 21'h002FFF
      && tr_pc >= 21'h002000 && tr_pc <= 21'h002FFF
    |=> !tr_blocked)
    else $error("block 2 read from own block refused");

  chk_block1_same: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
    tr_valid && tr_addr >= 21'h001000 && tr_addr <= 21'h001FFF
      && tr_pc >= 21'h001000 && tr_pc <= 21'h001FFF
    |=> !tr_blocked)
    else $error("block 1 read from own block refused");

  chk_block0_same: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    tr_valid && tr_addr >= 21'h000200 && tr_addr <= 21'h000FFF
      && tr_pc >= 21'h000200 && tr_pc <= 21'h000FFF
    |=> !tr_blocked)
    else $error("block 0 read from own block refused");

  chk_boot_allow: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    tr_valid && tr_addr <= 21'h0001FF && table_read_protect_high[0]
    |=> !tr_blocked && tr_rdata == $past(mem_rdata))
    else $error("boot block read refused with guard set");

  chk_boot_same: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    tr_valid && tr_addr <= 21'h0001FF && tr_pc <= 21'h0001FF
    |=> !tr_blocked)
    else $error("boot block read from own block refused");

  // ****************************************************************
  // Guard register checks
  // ****************************************************************
  chk_low_guard_write: assert property (@(posedge clk) disable iff (!rst_n) // [R1] [R2] [R3] [R4]
    psel && penable && pready && pwrite && pstrb[0] && paddr == 12'h000
    |=> table_read_protect_low == ($past(pwdata[7:0]) & 8'h0F))
    else $error("low guard register write wrong");

  chk_low_guard_hold: assert property (@(posedge clk) disable iff (!rst_n) // [R1] [R2] [R3] [R4]
    !(psel && penable && pwrite && pstrb[0] && paddr == 12'h000)
    |=> $stable(table_read_protect_low))
    else $error("low guard register changed without write");

  chk_high_guard_write: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    psel && penable && pready && pwrite && pstrb[0] && paddr == 12'h004
    |=> table_read_protect_high == ($past(pwdata[7:0]) & 8'h01))
    else $error("high guard register write wrong");

  chk_high_guard_hold: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    !(psel && penable && pwrite && pstrb[0] && paddr == 12'h004)
    |=> $stable(table_read_protect_high))
    else $error("high guard register changed without write");

  chk_read_data_hold: assert property (@(posedge clk) disable iff (!rst_n) // [R6] [R7]
    !(psel && !penable) |=> $stable(prdata) && $stable(pslverr))
    else $error("read data changed outside a setup cycle");

endmodule

// ==== design/trp_pkg.sv ====
// Constants and register map of the table read protection block
package trp_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned TR_ADDR_W   = 21;
  localparam int unsigned TR_DATA_W   = 8;
  localparam int unsigned APB_ADDR_W  = 12;
  localparam int unsigned REGION_NUM  = 5;
  localparam int unsigned PART_W      = 11;
  localparam int unsigned REVISION_W  = 5;

  // ****************************************************************
  // Region bounds, index 0 boot, 1..4 blocks 0..3
  // ****************************************************************
  localparam logic [REGION_NUM-1:0][TR_ADDR_W-1:0] REGION_LO = {
    21'h003000, 21'h002000, 21'h001000, 21'h000200, 21'h000000};
  localparam logic [REGION_NUM-1:0][TR_ADDR_W-1:0] REGION_HI = {
    21'h003FFF, 21'h002FFF, 21'h001FFF, 21'h000FFF, 21'h0001FF};
  localparam int unsigned RGN_BOOT = 0;
  localparam int unsigned RGN_BLK0 = 1;
  localparam int unsigned RGN_BLK1 = 2;
  localparam int unsigned RGN_BLK2 = 3;
  localparam int unsigned RGN_BLK3 = 4;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [APB_ADDR_W-1:0] OFS_PROTECT_LOW  = 12'h000;
  localparam logic [APB_ADDR_W-1:0] OFS_PROTECT_HIGH = 12'h004;
  localparam logic [APB_ADDR_W-1:0] OFS_IDENTITY_LOW = 12'h008;
  localparam logic [APB_ADDR_W-1:0] OFS_IDENTITY_HIGH = 12'h00C;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned BIT_BLOCK0_GUARD = 0;
  localparam int unsigned BIT_BLOCK1_GUARD = 1;
  localparam int unsigned BIT_BLOCK2_GUARD = 2;
  localparam int unsigned BIT_BLOCK3_GUARD = 3;
  localparam int unsigned BIT_BOOT_GUARD   = 0;
  localparam logic [7:0]  PROTECT_LOW_MASK  = 8'h0F;
  localparam logic [7:0]  PROTECT_HIGH_MASK = 8'h01;
  localparam logic [7:0]  PROTECT_LOW_RST   = 8'h0F;
  localparam logic [7:0]  PROTECT_HIGH_RST  = 8'h01;
  localparam int unsigned ID_REVISION_LSB  = 0;
  localparam int unsigned ID_PART_LOW_LSB  = 5;

  // Arbitrary identification values
  localparam logic [PART_W-1:0] PART_NUMBER      = 11'h2A5;
  localparam logic [REVISION_W-1:0] SILICON_REVISION = 5'h03;

  // Value returned by a refused table read
  localparam logic [TR_DATA_W-1:0] BLOCKED_DATA = 8'h00;

endpackage

// ==== design/trp_region_decode.sv ====
// Address to one-hot protection region decoder
`timescale 1ns/1ns
module trp_region_decode (
  input  wire logic [trp_pkg::TR_ADDR_W-1:0]  addr,
  output logic      [trp_pkg::REGION_NUM-1:0] region
);

  // ****************************************************************
  // Range compare per region
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < trp_pkg::REGION_NUM; g++) begin : g_rgn
      assign region[g] = (addr >= trp_pkg::REGION_LO[g]) && (addr <= trp_pkg::REGION_HI[g]);
    end
  endgenerate

endmodule

// ==== test/trp_mem_model.sv ====
// Program memory stand-in that answers table reads combinationally
`timescale 1ns/1ns
module trp_mem_model (
  input  wire logic [trp_pkg::TR_ADDR_W-1:0] mem_addr,
  output logic      [trp_pkg::TR_DATA_W-1:0] mem_rdata
);
  // Address-derived byte: bits 7:0 XOR bits 15:8 XOR 8'h5A
  assign mem_rdata = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h5A;
endmodule

// ==== test/trp_table_read_guard_test.sv ====
// Self-checking bench of the table read protection block
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module trp_table_read_guard_test;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        tr_valid, tr_rvalid, tr_blocked;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [20:0] tr_addr, tr_pc, mem_addr, lo, hi, oth;
  logic [7:0]  mem_rdata, tr_rdata;
  int          error_cnt, n_tests;

  trp_table_read_guard dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tr_valid(tr_valid), .tr_addr(tr_addr),
    .tr_pc(tr_pc), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .tr_rvalid(tr_rvalid),
    .tr_rdata(tr_rdata), .tr_blocked(tr_blocked));
  trp_mem_model mem_u (.mem_addr(mem_addr), .mem_rdata(mem_rdata));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      error_cnt++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task rchk(input logic [11:0] a, input logic [31:0] e, input logic e_err);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
    `CHK(err, e_err)
  endtask

  function automatic logic [7:0] exp_mem(input logic [20:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  task tr(input logic [20:0] a, input logic [20:0] pc, input logic blk);
    @(posedge clk);
    tr_valid <= 1'b1; tr_addr <= a; tr_pc <= pc;
    @(posedge clk);
    tr_valid <= 1'b0;
    #1;
    `CHK(tr_rvalid, 1'b1)
    `CHK(tr_blocked, blk)
    `CHK(tr_rdata, blk ? trp_pkg::BLOCKED_DATA : exp_mem(a))
  endtask

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    int r;
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; pstrb = 4'hF; tr_valid = 1'b0; tr_addr = 21'h0; tr_pc = 21'h0;
    error_cnt = 0; n_tests = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rchk(trp_pkg::OFS_PROTECT_LOW, 32'h0000000F, 1'b0);
    rchk(trp_pkg::OFS_PROTECT_HIGH, 32'h00000001, 1'b0);
    rchk(trp_pkg::OFS_IDENTITY_LOW,
      {24'h0, trp_pkg::PART_NUMBER[2:0], trp_pkg::SILICON_REVISION}, 1'b0);
    apb(1'b1, trp_pkg::OFS_IDENTITY_HIGH, 32'h000000FF);
    rchk(trp_pkg::OFS_IDENTITY_HIGH, {24'h0, trp_pkg::PART_NUMBER[10:3]}, 1'b0);
    rchk(12'h010, 32'h0, 1'b1);
    $display("test registers done");
    for (r = 0; r < 5; r++) begin
      lo = trp_pkg::REGION_LO[r];
      hi = trp_pkg::REGION_HI[r];
      oth = trp_pkg::REGION_LO[(r + 1) % 5];
      if (r == 0) apb(1'b1, trp_pkg::OFS_PROTECT_HIGH, 32'h0);
      else apb(1'b1, trp_pkg::OFS_PROTECT_LOW, 32'h0F ^ (32'h1 << (r - 1)));
      if (r > 0) rchk(trp_pkg::OFS_PROTECT_LOW, 32'h0F ^ (32'h1 << (r - 1)), 1'b0);
      tr(lo, oth, 1'b1);
      tr(hi, 21'h004000, 1'b1);
      tr(hi, lo, 1'b0);
      tr(hi + 21'h1, oth, 1'b0);
      apb(1'b1, r == 0 ? trp_pkg::OFS_PROTECT_HIGH : trp_pkg::OFS_PROTECT_LOW,
        r == 0 ? 32'h01 : 32'h0F);
      tr(lo, oth, 1'b0);
    end
    $display("test protection done");
    stop_test();
  end
endmodule
